// ### cca_pin_model.sv
// Far side of the two module pins: an outside level per pin and the
// resolved wire that the counter array sees back on its pin inputs.
// Assumes the array drives a pin only while its enable is low.
`timescale 1ns/100ps

module cca_pin_model (
	input  wire logic [1:0] i_level,
	input  wire logic [1:0] i_drive,
	input  wire logic [1:0] i_drive_oe_n,
	output logic      [1:0] o_wire
);
	// A released pin shows the outside source, never the last driven level.
	always_comb begin
		for (int m = 0; m < 2; m++) begin
			o_wire[m] = i_drive_oe_n[m] ? i_level[m] : i_drive[m];
		end
	end
endmodule : cca_pin_model

// ### cca_pkg.sv
// Constants for the two-module counter array: register indices,
// field positions, count sources, prescale counts and reset values.
// Assumes an APB slave with one 32-bit word per register index.
package cca_pkg;
	localparam int         ADDR_W      = 12;
	localparam int         NMOD        = 2;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CTRL    = 8'hD8;
	localparam logic [7:0] IDX_AMODE   = 8'hD9;
	localparam logic [7:0] IDX_M0_MODE = 8'hDA;
	localparam logic [7:0] IDX_M1_MODE = 8'hDB;
	localparam logic [7:0] IDX_CNT_L   = 8'hE9;
	localparam logic [7:0] IDX_CMP0_L  = 8'hEA;
	localparam logic [7:0] IDX_CMP1_L  = 8'hEB;
	localparam logic [7:0] IDX_EXT0    = 8'hF2;
	localparam logic [7:0] IDX_EXT1    = 8'hF3;
	localparam logic [7:0] IDX_CNT_H   = 8'hF9;
	localparam logic [7:0] IDX_CMP0_H  = 8'hFA;
	localparam logic [7:0] IDX_CMP1_H  = 8'hFB;
	// Array control register fields.
	localparam int         CTL_OVF     = 7;
	localparam int         CTL_RUN     = 6;
	// Array mode register fields.
	localparam int         AM_IDLE     = 7;
	localparam int         AM_CPS_HI   = 3;
	localparam int         AM_CPS_LO   = 1;
	localparam int         AM_ECF      = 0;
	// Module mode register fields.
	localparam int         MM_ECOM     = 6;
	localparam int         MM_CAPP     = 5;
	localparam int         MM_CAPN     = 4;
	localparam int         MM_MAT      = 3;
	localparam int         MM_TOG      = 2;
	localparam int         MM_PWM      = 1;
	localparam int         MM_EIRQ     = 0;
	// Pulse extension register fields.
	localparam int         EXT_RELOAD  = 1;
	localparam int         EXT_ACTIVE  = 0;
	// Count source select encodings.
	localparam logic [2:0] SRC_DIV12   = 3'h0;
	localparam logic [2:0] SRC_DIV2    = 3'h1;
	localparam logic [2:0] SRC_T0      = 3'h2;
	localparam logic [2:0] SRC_EXT     = 3'h3;
	localparam logic [2:0] SRC_SYS     = 3'h4;
	localparam logic [2:0] SRC_DIV4    = 3'h5;
	localparam logic [2:0] SRC_DIV6    = 3'h6;
	localparam logic [2:0] SRC_DIV8    = 3'h7;
	// Prescaler terminal counts (divisor minus one).
	localparam logic [3:0] PRE_12      = 4'hB;
	localparam logic [3:0] PRE_2       = 4'h1;
	localparam logic [3:0] PRE_4       = 4'h3;
	localparam logic [3:0] PRE_6       = 4'h5;
	localparam logic [3:0] PRE_8       = 4'h7;
	localparam logic [3:0] PRE_ZERO    = 4'h0;
	// Reset values and limits.
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] CNT_MAX    = 16'hFFFF;
	localparam logic [7:0]  BYTE_MAX   = 8'hFF;
	localparam logic        RST_PIN    = 1'b1;
endpackage : cca_pkg

// ### cca_top.sv
// Two-module counter array: shared 16-bit counter, two capture/compare
// modules with capture, timer, toggle and 8-bit pulse-width modes.
// Assumes an APB master, synchronous pin inputs and a one-cycle
// timer 0 overflow pulse.
//
// What this block does
// - Module interrupt enable gates the module event flag onto the request.
// - Toggle enable inverts the module pin on each counter match.
// - Match enable sets the module event flag on counter match.
// - Rise and fall capture enables arm positive, negative or both edges.
// - Compare enable switches the comparator; match, toggle, pulse need it.
// - Pulse mode makes 8-bit output; capture enables pick flagged edges.
// - Capture enables alone give 16-bit capture on selected pin edges.
// - Compare plus match is timer, plus toggle is fast output, zero is idle.
// - Counter low and high bytes are software read/write and reset zero.
// - Compare byte pair holds capture/compare value or pulse duty.
// - Both compare bytes of each module reset to zero.
// - Extension register: bit 1 pairs high byte, bit 0 low byte.
// - Idle halt bit stops the counter while the processor idles.
// - Counter overflow sets overflow flag; its enable raises a request.
// - Only software clears the overflow flag.
// - Module event flags set by hardware, cleared only by software.
// - Count source picks divided clocks, clock, timer 0 or count pin.
// - A valid capture edge copies the counter into the compare pair.
// - Pulse output low below 9-bit active value; reload on low byte wrap.
`timescale 1ns/100ps

module cca_top (
	input  wire logic                       i_clk,
	input  wire logic                       i_resetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [cca_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       i_idle,
	input  wire logic                       i_timer0_ovf,
	input  wire logic                       i_external_count_pin,
	input  wire logic [cca_pkg::NMOD-1:0]   i_module_pin,
	output logic      [cca_pkg::NMOD-1:0]   o_module_pin,
	output logic      [cca_pkg::NMOD-1:0]   o_module_pin_oe_n,
	output logic                            o_irq
);
	import cca_pkg::*;

	typedef struct packed {
		logic [15:0]           cnt;
		logic [3:0]            pre;
		logic                  ovf;
		logic                  run;
		logic [NMOD-1:0]       evf;
		logic                  idle_halt;
		logic [2:0]            src;
		logic                  ovf_ie;
		logic [NMOD-1:0][6:0]  mmode;
		logic [NMOD-1:0][7:0]  cmp_l;
		logic [NMOD-1:0][7:0]  cmp_h;
		logic [NMOD-1:0]       ext_act;
		logic [NMOD-1:0]       ext_rld;
		logic [NMOD-1:0]       pin;
		logic [NMOD-1:0]       pin_oe_n;
		logic [NMOD-1:0]       pin_in_q;
		logic                  ecnt_q;
		logic [31:0]           rdata;
		logic                  ready;
		logic                  slverr;
		logic                  irq;
	} cca_state_t;

	cca_state_t q_r;
	cca_state_t s_nxt;

	logic [7:0]      idx;
	logic            in_map;
	logic            hit;
	logic [7:0]      rd_byte;
	logic            wr;
	logic [7:0]      wb;
	logic            src_pulse;
	logic            tick;
	logic            low_wrap;
	logic [NMOD-1:0] match;
	logic [NMOD-1:0] cap_ev;
	logic [NMOD-1:0] pwm_on;
	logic [NMOD-1:0] flag_ev;
	logic [3:0]      pre_top;
	logic [8:0]      act;
	logic            rise;
	logic            fall;

	assign idx    = paddr[9:2];
	assign in_map = (paddr[ADDR_W-1:10] == 2'b00) && (paddr[1:0] == 2'b00);
	assign wr     = psel && penable && pwrite && q_r.ready && hit;
	assign wb     = pwdata[7:0];

	// Read decode; reserved bits read as zero.
	always_comb begin
		hit     = in_map;
		rd_byte = RST_BYTE;
		unique case (idx)
			IDX_CTRL:    rd_byte = {q_r.ovf, q_r.run, 4'h0, q_r.evf};
			IDX_AMODE:   rd_byte = {q_r.idle_halt, 3'h0, q_r.src, q_r.ovf_ie};
			IDX_M0_MODE: rd_byte = {1'b0, q_r.mmode[0]};
			IDX_M1_MODE: rd_byte = {1'b0, q_r.mmode[1]};
			IDX_CNT_L:   rd_byte = q_r.cnt[7:0];
			IDX_CNT_H:   rd_byte = q_r.cnt[15:8];
			IDX_CMP0_L:  rd_byte = q_r.cmp_l[0];
			IDX_CMP1_L:  rd_byte = q_r.cmp_l[1];
			IDX_CMP0_H:  rd_byte = q_r.cmp_h[0];
			IDX_CMP1_H:  rd_byte = q_r.cmp_h[1];
			IDX_EXT0:    rd_byte = {6'h00, q_r.ext_rld[0], q_r.ext_act[0]};
			IDX_EXT1:    rd_byte = {6'h00, q_r.ext_rld[1], q_r.ext_act[1]};
			default:     hit     = 1'b0;
		endcase
	end

	// Count source selection.
	always_comb begin
		pre_top   = PRE_ZERO;
		src_pulse = 1'b0;
		unique case (q_r.src)
			SRC_DIV12: pre_top = PRE_12;
			SRC_DIV2:  pre_top = PRE_2;
			SRC_DIV4:  pre_top = PRE_4;
			SRC_DIV6:  pre_top = PRE_6;
			SRC_DIV8:  pre_top = PRE_8;
			SRC_SYS:   pre_top = PRE_ZERO;
			SRC_T0:    src_pulse = i_timer0_ovf;
			SRC_EXT:   src_pulse = q_r.ecnt_q && !i_external_count_pin;
		endcase
		if (q_r.src != SRC_T0 && q_r.src != SRC_EXT) begin
			src_pulse = (q_r.pre >= pre_top);
		end
	end

	// Idle halt only gates the counter; the prescaler keeps its phase.
	assign tick     = q_r.run && !(q_r.idle_halt && i_idle) && src_pulse;
	assign low_wrap = tick && (q_r.cnt[7:0] == BYTE_MAX);

	always_comb begin
		s_nxt    = q_r;
		match    = '0;
		cap_ev   = '0;
		pwm_on   = '0;
		flag_ev  = '0;
		act      = 9'h000;
		rise     = 1'b0;
		fall     = 1'b0;

		s_nxt.ecnt_q   = i_external_count_pin;
		s_nxt.pin_in_q = i_module_pin;
		if (q_r.src != SRC_T0 && q_r.src != SRC_EXT) begin
			s_nxt.pre = (q_r.pre >= pre_top) ? PRE_ZERO : 4'(q_r.pre + 4'h1);
		end

		// Counter: wrap from all ones is the overflow event.
		if (tick) begin
			s_nxt.cnt = 16'(q_r.cnt + 16'h0001);
		end

		// Software writes; hardware events below take precedence.
		if (wr) begin
			unique case (idx)
				IDX_CTRL: begin
					s_nxt.ovf = wb[CTL_OVF];
					s_nxt.run = wb[CTL_RUN];
					s_nxt.evf = wb[NMOD-1:0];
				end
				IDX_AMODE: begin
					s_nxt.idle_halt = wb[AM_IDLE];
					s_nxt.src       = wb[AM_CPS_HI:AM_CPS_LO];
					s_nxt.ovf_ie    = wb[AM_ECF];
				end
				IDX_M0_MODE: s_nxt.mmode[0] = wb[6:0];
				IDX_M1_MODE: s_nxt.mmode[1] = wb[6:0];
				IDX_CNT_L:   s_nxt.cnt[7:0]  = wb;
				IDX_CNT_H:   s_nxt.cnt[15:8] = wb;
				IDX_CMP0_L:  s_nxt.cmp_l[0] = wb;
				IDX_CMP1_L:  s_nxt.cmp_l[1] = wb;
				IDX_CMP0_H:  s_nxt.cmp_h[0] = wb;
				IDX_CMP1_H:  s_nxt.cmp_h[1] = wb;
				IDX_EXT0: begin
					s_nxt.ext_rld[0] = wb[EXT_RELOAD];
					s_nxt.ext_act[0] = wb[EXT_ACTIVE];
				end
				IDX_EXT1: begin
					s_nxt.ext_rld[1] = wb[EXT_RELOAD];
					s_nxt.ext_act[1] = wb[EXT_ACTIVE];
				end
				default: s_nxt.ovf = q_r.ovf;
			endcase
		end

		// Overflow sets the flag and wins over a clearing write.
		if (tick && q_r.cnt == CNT_MAX) begin
			s_nxt.ovf = 1'b1;
		end

		for (int m = 0; m < NMOD; m++) begin
			rise = !q_r.pin_in_q[m] && i_module_pin[m];
			fall = q_r.pin_in_q[m] && !i_module_pin[m];
			pwm_on[m] = q_r.mmode[m][MM_ECOM] && q_r.mmode[m][MM_PWM];
			// Full 16-bit compare against the freshly advanced counter.
			match[m] = tick && q_r.mmode[m][MM_ECOM] && !q_r.mmode[m][MM_PWM]
				&& (s_nxt.cnt == {q_r.cmp_h[m], q_r.cmp_l[m]});
			cap_ev[m] = !q_r.mmode[m][MM_MAT] && !q_r.mmode[m][MM_TOG]
				&& !q_r.mmode[m][MM_PWM]
				&& ((q_r.mmode[m][MM_CAPP] && rise)
				|| (q_r.mmode[m][MM_CAPN] && fall));
			if (cap_ev[m]) begin
				s_nxt.cmp_h[m] = q_r.cnt[15:8];
				s_nxt.cmp_l[m] = q_r.cnt[7:0];
			end
			if (match[m] && q_r.mmode[m][MM_MAT]) begin
				flag_ev[m] = 1'b1;
			end
			if (cap_ev[m]) begin
				flag_ev[m] = 1'b1;
			end
			if (match[m] && q_r.mmode[m][MM_TOG]) begin
				s_nxt.pin[m] = !q_r.pin[m];
			end
			if (pwm_on[m]) begin
				// Reloading on the low-byte wrap avoids glitches on duty updates.
				if (low_wrap) begin
					s_nxt.cmp_l[m]   = s_nxt.cmp_h[m];
					s_nxt.ext_act[m] = s_nxt.ext_rld[m];
				end
				act = {s_nxt.ext_act[m], s_nxt.cmp_l[m]};
				s_nxt.pin[m] = ({1'b0, s_nxt.cnt[7:0]} >= act);
				if (q_r.mmode[m][MM_EIRQ]) begin
					if ((q_r.mmode[m][MM_CAPP] && s_nxt.pin[m] && !q_r.pin[m])
						|| (q_r.mmode[m][MM_CAPN] && !s_nxt.pin[m] && q_r.pin[m])) begin
						flag_ev[m] = 1'b1;
					end
				end
			end
			if (flag_ev[m]) begin
				s_nxt.evf[m] = 1'b1;
			end
			s_nxt.pin_oe_n[m] = !(q_r.mmode[m][MM_ECOM]
				&& (q_r.mmode[m][MM_TOG] || q_r.mmode[m][MM_PWM]));
		end

		s_nxt.irq = (s_nxt.ovf && s_nxt.ovf_ie)
			|| |(s_nxt.evf & {s_nxt.mmode[1][MM_EIRQ], s_nxt.mmode[0][MM_EIRQ]});

		// Zero-wait APB: answer in the first access cycle.
		s_nxt.ready  = psel && !penable;
		s_nxt.slverr = psel && !penable && !hit;
		s_nxt.rdata  = (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q_r          <= '0;
			q_r.pin      <= {NMOD{RST_PIN}};
			q_r.pin_oe_n <= '1;
			q_r.pin_in_q <= '0;
		end else begin
			q_r <= s_nxt;
		end
	end

	assign prdata            = q_r.rdata;
	assign pready            = q_r.ready;
	assign pslverr           = q_r.slverr;
	assign o_module_pin      = q_r.pin;
	assign o_module_pin_oe_n = q_r.pin_oe_n;
	assign o_irq             = q_r.irq;

	logic ctrl_wr;
	logic cnt_wr;
	assign ctrl_wr = wr && (idx == IDX_CTRL);
	assign cnt_wr  = wr && (idx == IDX_CNT_L || idx == IDX_CNT_H);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	a_ovf_set: assert property (tick && q_r.cnt == CNT_MAX |=> q_r.ovf)
		else $error("overflow flag not set on wrap");
	a_ovf_sticky: assert property (q_r.ovf && !ctrl_wr |=> q_r.ovf)
		else $error("overflow flag cleared by hardware");
	a_evf_sticky: assert property (q_r.evf[0] && !ctrl_wr |=> q_r.evf[0])
		else $error("module event flag cleared by hardware");
	a_match_flag: assert property (match[0] && q_r.mmode[0][MM_MAT] |=> q_r.evf[0])
		else $error("match did not set module event flag");
	a_toggle_pin: assert property (match[0] && q_r.mmode[0][MM_TOG]
		|=> o_module_pin[0] != $past(o_module_pin[0]))
		else $error("pin did not toggle on match");
	a_capture_copy: assert property (cap_ev[0]
		|=> {q_r.cmp_h[0], q_r.cmp_l[0]} == $past(q_r.cnt) && q_r.evf[0])
		else $error("capture did not copy counter");
	a_pwm_level: assert property (pwm_on[0] && $past(pwm_on[0])
		|-> o_module_pin[0] == ({1'b0, q_r.cnt[7:0]} >= {q_r.ext_act[0], q_r.cmp_l[0]}))
		else $error("pulse output level wrong");
	a_idle_halt: assert property (q_r.idle_halt && i_idle && !cnt_wr
		|=> q_r.cnt == $past(q_r.cnt))
		else $error("counter moved during idle halt");
	a_run_stop: assert property (!q_r.run && !cnt_wr ##1 !q_r.run
		|-> q_r.cnt == $past(q_r.cnt))
		else $error("counter moved while stopped");
	a_irq_gate: assert property (o_irq |-> (q_r.ovf && q_r.ovf_ie)
		|| (q_r.evf[0] && q_r.mmode[0][MM_EIRQ])
		|| (q_r.evf[1] && q_r.mmode[1][MM_EIRQ]))
		else $error("request without enabled flag");
	a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

endmodule : cca_top

// ### testbench.sv
// Self-checking bench for the counter array: registers, count sources,
// overflow, idle halt, match, toggle, capture and pulse-width output.
// Assumes cca_pkg, cca_top and cca_pin_model are compiled first.
`timescale 1ns/100ps

module testbench;
	import cca_pkg::*;
	logic              i_clk = 1'b0;
	logic              i_resetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              i_idle = 1'b0;
	logic              i_timer0_ovf = 1'b0;
	logic              i_external_count_pin = 1'b1;
	logic [1:0]        lvl = 2'h3;
	logic [1:0]        pin_w;
	logic [1:0]        pin_o;
	logic [1:0]        pin_oe_n;
	logic              o_irq;
	logic [7:0]        seed = 8'h56;
	logic [7:0]        d;
	logic              err;
	int                errors = 0;
	int                total_checks = 0;
	int                cyc = 0;
	int                c0;
	int                hi;
	logic [7:0]        regs [6] = '{IDX_CNT_L, IDX_CNT_H, IDX_CMP0_L, IDX_CMP0_H, IDX_CMP1_L,
	                               IDX_CMP1_H};
	int                divs [8] = '{12, 2, 3, 8, 1, 4, 6, 8};

	always #5 i_clk = ~i_clk;
	// Timer 0 overflows every third cycle and the count pin falls every eighth.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_timer0_ovf <= (cyc % 3 == 2);
		i_external_count_pin <= cyc[2];
	end

	cca_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .i_idle(i_idle), .i_timer0_ovf(i_timer0_ovf),
		.i_external_count_pin(i_external_count_pin), .i_module_pin(pin_w),
		.o_module_pin(pin_o), .o_module_pin_oe_n(pin_oe_n), .o_irq(o_irq));
	cca_pin_model pins (.i_level(lvl), .i_drive(pin_o), .i_drive_oe_n(pin_oe_n), .o_wire(pin_w));

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr

	function automatic logic [7:0] amode(input logic idle, input logic [2:0] src, input logic ecf);
		return {idle, 3'h0, src, ecf};
	endfunction : amode

	// High cycles out of n for a duty value; above a byte the output never rises.
	function automatic int pwm_high(input int act, input int n);
		return (act > 255) ? 0 : n * (256 - act) / 256;
	endfunction : pwm_high

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge i_clk);
		penable <= 1'b1;
		// The answer is taken at the rising edge where pready is seen high.
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		d = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			chk(1'b0, 1'b1, "no pready");
			close_out;
		end
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, idx, v);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
		apb(1'b0, idx, 8'h00);
		chk(d, exp, what);
	endtask : rdc

	task automatic run_from(input logic [15:0] cnt);
		wr(IDX_CNT_L, cnt[7:0]);
		wr(IDX_CNT_H, cnt[15:8]);
		wr(IDX_CTRL, 8'h40);
	endtask : run_from

	task automatic match_run(input logic [7:0] mode, input logic [15:0] cnt,
	                         input logic [7:0] ectl, input logic epin, input logic eirq);
		wr(IDX_M0_MODE, mode);
		run_from(cnt);
		repeat (40) @(posedge i_clk);
		rdc(IDX_CTRL, ectl, "match flag");
		chk(pin_w[0], epin, "match pin");
		chk(o_irq, eirq, "match irq");
		wr(IDX_CTRL, 8'h00);
	endtask : match_run

	task automatic cap_run(input int m, input logic [7:0] mode, input logic start,
	                       input logic both);
		logic [7:0] vl;
		logic [7:0] vh;
		vl = lfsr(seed);
		vh = lfsr(vl);
		seed = vh;
		lvl[m] <= start;
		wr(IDX_M0_MODE + m, mode);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_CNT_L, vl);
		wr(IDX_CNT_H, vh);
		lvl[m] <= ~start;
		repeat (4) @(posedge i_clk);
		rdc(IDX_CMP0_L + m, vl, "capture low");
		rdc(IDX_CMP0_H + m, vh, "capture high");
		rdc(IDX_CTRL, 8'h01 << m, "capture flag");
		wr(IDX_CTRL, 8'h00);
		lvl[m] <= start;
		repeat (4) @(posedge i_clk);
		rdc(IDX_CTRL, both ? (8'h01 << m) : 8'h00, "edge arm");
		wr(IDX_M0_MODE + m, 8'h00);
	endtask : cap_run

	initial begin
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		foreach (regs[i]) rdc(regs[i], RST_BYTE, "reset value");
		foreach (regs[i]) begin
			seed = lfsr(seed);
			wr(regs[i], seed);
			rdc(regs[i], seed, "readback");
		end
		wr(IDX_EXT0, 8'hFF);
		rdc(IDX_EXT0, 8'h03, "ext bits");
		wr(8'h00, 8'h5A);
		chk(err, 1'b1, "unmapped write");
		rdc(8'h00, 8'h00, "unmapped read");
		$display("registers done");
		for (int s = 0; s < 8; s++) begin
			wr(IDX_AMODE, amode(1'b0, s[2:0], 1'b0));
			run_from(16'h0000);
			c0 = cyc;
			repeat (120) @(posedge i_clk);
			wr(IDX_CTRL, 8'h00);
			c0 = (cyc - c0) / divs[s];
			apb(1'b0, IDX_CNT_L, 8'h00);
			chk(d + 3 >= c0 && d <= c0 + 3, 1'b1, "count rate");
		end
		i_idle <= 1'b1;
		wr(IDX_AMODE, amode(1'b1, SRC_SYS, 1'b0));
		run_from(16'h0000);
		repeat (20) @(posedge i_clk);
		wr(IDX_CTRL, 8'h00);
		i_idle <= 1'b0;
		rdc(IDX_CNT_L, 8'h00, "idle halt");
		wr(IDX_AMODE, amode(1'b0, SRC_SYS, 1'b1));
		run_from(16'hFFFF);
		repeat (4) @(posedge i_clk);
		rdc(IDX_CTRL, 8'hC0, "overflow");
		chk(o_irq, 1'b1, "overflow irq");
		rdc(IDX_CNT_H, 8'h00, "wrap");
		repeat (50) @(posedge i_clk);
		rdc(IDX_CTRL, 8'hC0, "overflow sticky");
		wr(IDX_AMODE, amode(1'b0, SRC_SYS, 1'b0));
		repeat (2) @(posedge i_clk);
		chk(o_irq, 1'b0, "overflow irq off");
		wr(IDX_CTRL, 8'h00);
		rdc(IDX_CTRL, 8'h00, "overflow clear");
		$display("counter done");
		wr(IDX_CMP0_L, 8'h10);
		wr(IDX_CMP0_H, 8'h01);
		match_run(8'h0D, 16'h0100, 8'h40, 1'b1, 1'b0);
		match_run(8'h4D, 16'h0005, 8'h40, 1'b1, 1'b0);
		match_run(8'h4D, 16'h0100, 8'h41, 1'b0, 1'b1);
		match_run(8'h49, 16'h0100, 8'h41, 1'b1, 1'b1);
		match_run(8'h4C, 16'h0100, 8'h41, 1'b1, 1'b0);
		wr(IDX_M0_MODE, 8'h00);
		$display("match done");
		cap_run(0, 8'h20, 1'b0, 1'b0);
		cap_run(0, 8'h10, 1'b1, 1'b0);
		cap_run(1, 8'h30, 1'b0, 1'b1);
		cap_run(1, 8'h10, 1'b1, 1'b0);
		$display("capture done");
		wr(IDX_EXT0, 8'h00);
		wr(IDX_M0_MODE, 8'h63);
		wr(IDX_CMP0_L, 8'h40);
		wr(IDX_CMP0_H, 8'h40);
		run_from(16'h0000);
		for (int k = 0; k < 2; k++) begin
			hi = 0;
			repeat (512) @(negedge i_clk) hi += int'(pin_w[0]);
			c0 = pwm_high(k * 256 + 64, 512);
			chk(hi + 4 >= c0 && hi <= c0 + 4, 1'b1, "duty");
			rdc(IDX_CTRL, k ? 8'h40 : 8'h41, "duty edge flag");
			wr(IDX_EXT0, 8'h03);
			wr(IDX_CTRL, 8'h40);
		end
		$display("pulse done");
		close_out;
	end
endmodule : testbench
